// [bench/interval_timer_asserts.sv]
// Port-level properties of the interval timer
`include "interval_timer_map.svh"
module interval_timer_asserts #(
    parameter int CNT_W = 14,
    parameter int DIV = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Serial bus and level 3
    input wire logic [`ITMR_SEL_W-1:0] io_sel,
    input wire logic io_wr,
    input wire logic io_wdata,
    input wire logic io_rdata_q,
    input wire logic int_level3_q,
    // Avalon
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    logic mode_q;
    // Shadow of the mode bit, so clock-mode reads can be judged
    always_ff @(posedge clk) begin
        if (!reset_n) mode_q <= 1'b0;
        else if (io_wr && io_sel == `ITMR_SEL_MODE) mode_q <= io_wdata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wait_answer_a: assert property (
        $rose(read) |=> !waitrequest) else $error("read not answered in one cycle");
    wait_pulse_a: assert property (
        !waitrequest |=> waitrequest) else $error("waitrequest low too long");
    wait_idle_a: assert property (
        !read && !write |=> waitrequest) else $error("waitrequest low while idle");
    rdata_hold_a: assert property (
        !read |=> $stable(readdata)) else $error("readdata moved without read");
    int_hold_a: assert property (
        int_level3_q && !(io_wr && io_sel == `ITMR_SEL_CLR)
        && !$past(io_wr && io_sel == `ITMR_SEL_CLR) |=> int_level3_q)
        else $error("level 3 request dropped uncleared");
    int_clear_a: assert property (
        !mode_q && io_wr && io_sel == `ITMR_SEL_CLR && io_wdata |=> !int_level3_q)
        else $error("level 3 request not cleared");
    mode_read_a: assert property (
        mode_q && io_sel == `ITMR_SEL_MODE && !io_wr |=> io_rdata_q)
        else $error("clock mode not reported");
    sel_range_a: assert property (
        io_sel[4] |=> !io_rdata_q) else $error("high select read nonzero");
endmodule : interval_timer_asserts

bind interval_timer interval_timer_asserts #(.CNT_W(CNT_W), .DIV(DIV)) interval_timer_asserts_i (
    .clk, .reset_n, .io_sel, .io_wr, .io_wdata, .io_rdata_q, .int_level3_q,
    .read, .write, .readdata, .waitrequest);

// [bench/serial_host_model.sv]
// Host processor model on the bit-serial bus
`include "interval_timer_map.svh"
module serial_host_model (
    // Clock
    input wire logic clk,
    // Bit-serial bus
    output logic [4:0] io_sel,
    output logic io_wr,
    output logic io_wdata,
    input wire logic io_rdata_q
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        io_sel = 5'h00;
        io_wr = 1'b0;
        io_wdata = 1'b0;
    end
    // Released data shows the inverse, so a stale bit never looks valid
    task automatic put(input logic [4:0] s, input logic b);
        @(posedge clk);
        io_sel <= s;
        io_wr <= 1'b1;
        io_wdata <= b;
        @(posedge clk);
        io_wr <= 1'b0;
        io_wdata <= ~b;
    endtask : put
    task automatic get(input logic [4:0] s, output logic b);
        @(posedge clk);
        io_sel <= s;
        @(posedge clk);
        #1 b = io_rdata_q;
    endtask : get
    task automatic load(input logic [13:0] v);
        put(`ITMR_SEL_MODE, 1'b1);
        for (int k = 1; k <= 14; k++) put(5'(k), v[k-1]);
    endtask : load
    task automatic ack();
        put(`ITMR_SEL_MODE, 1'b0);
        put(`ITMR_SEL_CLR, 1'b1);
    endtask : ack
    task automatic capture(output logic [13:0] c);
        put(`ITMR_SEL_MODE, 1'b0);
        repeat (64) @(posedge clk);
        put(`ITMR_SEL_MODE, 1'b1);
        for (int k = 1; k <= 14; k++) get(5'(k), c[k-1]);
    endtask : capture
endmodule : serial_host_model

// [bench/tb_interval_timer.sv]
// Self-checking bench for the interval timer
`include "interval_timer_map.svh"
module tb_interval_timer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, read, write, io_wr, io_wdata, io_rdata_q, int_level3_q, waitrequest;
    logic irq_q, b;
    logic [4:0] io_sel;
    logic [3:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [13:0] c;
    int mismatches, checks, cyc, t0;
    interval_timer interval_timer_i (.clk, .reset_n, .io_sel, .io_wr, .io_wdata, .io_rdata_q,
        .int_level3_q, .address, .read, .write, .writedata, .readdata, .waitrequest, .irq_q);
    serial_host_model serial_host_model_i (.clk, .io_sel, .io_wr, .io_wdata, .io_rdata_q);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : av
    task automatic tally_and_finish();
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic t_regs();
        av(1'b1, `ITMR_OFF_MASK, 32'h3);
        av(1'b0, `ITMR_OFF_MASK, 32'h0);
        chk("mask", 32'h3, rd);
        av(1'b1, 4'hc, 32'hffffffff);
        av(1'b0, 4'hc, 32'h0);
        chk("unmapped", 32'h0, rd);
        av(1'b0, `ITMR_OFF_STATE, 32'h0);
        chk("state", 32'h0, rd);
    endtask : t_regs
    task automatic t_start();
        serial_host_model_i.ack();
        serial_host_model_i.put(`ITMR_SEL_MODE, 1'b1);
        for (int k = 1; k <= 13; k++) serial_host_model_i.put(5'(k), k == 4);
        av(1'b0, `ITMR_OFF_STATE, 32'h0);
        chk("held", 32'h10000, rd);
        serial_host_model_i.put(5'h0e, 1'b0);
        t0 = cyc;
        av(1'b0, `ITMR_OFF_STATE, 32'h0);
        chk("run", 32'h50008, rd);
        chk("irq", 32'h1, irq_q);
        av(1'b0, `ITMR_OFF_STATUS, 32'h0);
        chk("status", 32'h2, rd);
        repeat (2) @(posedge clk);
        chk("irq", 32'h0, irq_q);
    endtask : t_start
    task automatic t_expire();
        av(1'b1, `ITMR_OFF_MASK, 32'h2);
        while (cyc < t0 + 508) @(posedge clk);
        chk("early", 32'h0, int_level3_q);
        while (cyc < t0 + 516) @(posedge clk);
        chk("int", 32'h1, int_level3_q);
        chk("masked", 32'h0, irq_q);
        av(1'b1, `ITMR_OFF_MASK, 32'h3);
        repeat (2) @(posedge clk);
        chk("irq", 32'h1, irq_q);
        av(1'b0, `ITMR_OFF_STATUS, 32'h0);
        chk("status", 32'h1, rd);
        while (cyc < t0 + 620) @(posedge clk);
        chk("held", 32'h1, int_level3_q);
        serial_host_model_i.get(`ITMR_SEL_TOP, b);
        chk("pend", 32'h1, b);
        serial_host_model_i.ack();
        repeat (2) @(posedge clk);
        chk("cleared", 32'h0, int_level3_q);
        chk("irq", 32'h0, irq_q);
        serial_host_model_i.get(`ITMR_SEL_CLR, b);
        chk("mask3", 32'h1, b);
        serial_host_model_i.get(`ITMR_SEL_MODE, b);
        chk("mode", 32'h0, b);
    endtask : t_expire
    task automatic t_readback();
        serial_host_model_i.load(14'h3fff);
        repeat (600) @(posedge clk);
        serial_host_model_i.capture(c);
        chk("count", 32'h3ff5, c);
        serial_host_model_i.get(`ITMR_SEL_MODE, b);
        chk("mode", 32'h1, b);
        serial_host_model_i.get(5'h1f, b);
        chk("sel31", 32'h0, b);
    endtask : t_readback
    initial begin
        reset_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        writedata = 32'h0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk("waitrequest", 32'h1, waitrequest);
        t_regs();
        t_start();
        t_expire();
        t_readback();
        tally_and_finish();
    end
endmodule : tb_interval_timer

// [include/countdown_if.sv]
// Carrier between the timer control and its countdown engine
`include "interval_timer_map.svh"
interface countdown_if;
    logic start;
    logic [`ITMR_CNT_W-1:0] load;
    logic [`ITMR_CNT_W-1:0] count;
    logic expired;
    logic running;

    modport ctrl (
        output start,
        output load,
        input count,
        input expired,
        input running
    );

    modport engine (
        input start,
        input load,
        output count,
        output expired,
        output running
    );
endinterface : countdown_if

// [include/interval_timer_map.svh]
// Offsets, field positions, reset values and timing counts of the interval timer
`ifndef INTERVAL_TIMER_MAP_SVH
`define INTERVAL_TIMER_MAP_SVH

// Countdown width and prescale
`define ITMR_CNT_W 14
`define ITMR_DIV 64
`define ITMR_NOMINAL_HZ 3000000
`define ITMR_CLK_HZ 100000000

// Bit-serial select positions
`define ITMR_SEL_W 5
`define ITMR_SEL_MODE 5'h00
`define ITMR_SEL_INT_FIRST 5'h01
`define ITMR_SEL_INT_LAST 5'h0e
`define ITMR_SEL_CLR 5'h03
`define ITMR_SEL_TOP 5'h0f

// Avalon byte offsets
`define ITMR_AV_ADDR_W 4
`define ITMR_OFF_STATUS 4'h0
`define ITMR_OFF_MASK 4'h4
`define ITMR_OFF_STATE 4'h8

// Status and mask fields
`define ITMR_EVT_W 2
`define ITMR_EVT_EXPIRED 0
`define ITMR_EVT_STARTED 1

// State register fields
`define ITMR_ST_MODE 16
`define ITMR_ST_PEND 17
`define ITMR_ST_RUN 18

// Reset values
`define ITMR_RST_INTERVAL 14'h0000
`define ITMR_RST_LEVEL_MASK 15'h0000
`define ITMR_RST_EVT 2'h0
`define ITMR_RST_RDATA 32'h0000_0000

`endif

// [include/interval_timer_pkg.sv]
// Types shared by the interval timer modules
`include "interval_timer_map.svh"
package interval_timer_pkg;

    typedef enum logic [0:0] {
        MODE_INTR  = 1'b0,
        MODE_CLOCK = 1'b1
    } mode_e;

    typedef logic [`ITMR_CNT_W-1:0] count_t;

endpackage : interval_timer_pkg

// [rtl/countdown_engine.sv]
// Prescaled down counter that reloads and flags each pass through zero
`include "interval_timer_map.svh"
module countdown_engine #(
    parameter int CNT_W = `ITMR_CNT_W,
    parameter int DIV = `ITMR_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control side
    countdown_if.engine cd
);
    localparam int PRE_W = $clog2(DIV);

    if (CNT_W != `ITMR_CNT_W || DIV < 2 || (1 << PRE_W) != DIV) begin : g_bad_param
        $error("countdown_engine: unsupported width or divider");
    end

    typedef struct packed {
        logic [PRE_W-1:0] presc;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] reload;
        logic running;
        logic expired;
    } eng_s;

    eng_s s_q;
    eng_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.expired = 1'b0;
        if (cd.start) begin
            // Loading zero parks the counter rather than firing at once
            s_d.count = cd.load;
            s_d.reload = cd.load;
            s_d.presc = '0;
            s_d.running = (cd.load != '0);
        end else if (s_q.running) begin
            s_d.presc = s_q.presc + PRE_W'(1);
            if (s_q.presc == PRE_W'(DIV - 1)) begin
                if (s_q.count == CNT_W'(1)) begin
                    // Periodic: reload so software need not rearm every pass
                    s_d.count = s_q.reload;
                    s_d.expired = 1'b1;
                end else begin
                    s_d.count = s_q.count - CNT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cd.count = s_q.count;
    assign cd.expired = s_q.expired;
    assign cd.running = s_q.running;

endmodule : countdown_engine

// [rtl/interval_timer.sv]
// Interval timer with bit-serial host port, interrupt level 3 and Avalon status
//
// Function
// - First bit one on select 0 enters clock mode
// - Zero written to select 0 restores interrupt mode
// - Clock mode bits 1..14 load interval
// - Only writing bit 14 starts countdown
// - Count decrements once every 64 clocks
// - Full 14-bit interval counts 16383 steps
// - Reaching zero raises level 3 request when mask bit 3 is set
// - One on select 3 in interrupt mode clears pending interrupt
// - Clock mode reads of bits 1..14 return captured count
`include "interval_timer_map.svh"
module interval_timer #(
    parameter int CNT_W = `ITMR_CNT_W,
    parameter int DIV = `ITMR_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bit-serial I/O bus
    input wire logic [`ITMR_SEL_W-1:0] io_sel,
    input wire logic io_wr,
    input wire logic io_wdata,
    output logic io_rdata_q,
    // Interrupt request to the processor
    output logic int_level3_q,
    // Avalon-MM slave
    input wire logic [`ITMR_AV_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Event interrupt
    output logic irq_q
);
    if (CNT_W != `ITMR_CNT_W) begin : g_bad_width
        $error("interval_timer: counter width must match select map");
    end

    typedef struct packed {
        interval_timer_pkg::mode_e mode;
        logic [CNT_W-1:0] interval;
        logic [15:1] level_mask;
        logic pend;
        logic [CNT_W-1:0] capture;
        logic io_rdata;
        logic int3;
        logic start;
        logic [`ITMR_EVT_W-1:0] evt;
        logic [`ITMR_EVT_W-1:0] evt_mask;
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
    } top_s;

    top_s s_q;
    top_s s_d;

    countdown_if cd ();

    countdown_engine #(
        .CNT_W(CNT_W),
        .DIV(DIV)
    ) u_engine (
        .clk(clk),
        .reset_n(reset_n),
        .cd(cd)
    );

    // Start is a registered pulse, so the load value is the stored interval
    assign cd.start = s_q.start;
    assign cd.load = s_q.interval;

    logic sel_is_mode;
    logic sel_in_interval;
    logic sel_in_mask;
    logic [3:0] sel_idx;
    logic av_take;
    logic av_first;
    logic [`ITMR_EVT_W-1:0] evt_set;
    logic [31:0] state_word;

    always_comb begin
        sel_is_mode = (io_sel == `ITMR_SEL_MODE);
        sel_in_interval = (io_sel >= `ITMR_SEL_INT_FIRST) && (io_sel <= `ITMR_SEL_INT_LAST);
        sel_in_mask = (io_sel >= `ITMR_SEL_INT_FIRST) && (io_sel <= `ITMR_SEL_TOP);
        sel_idx = io_sel[3:0];
        // A request is taken on the edge where waitrequest is already low
        av_take = (read || write) && !s_q.waitreq;
        av_first = (read || write) && s_q.waitreq;
        state_word = '0;
        state_word[CNT_W-1:0] = cd.count;
        state_word[`ITMR_ST_MODE] = s_q.mode;
        state_word[`ITMR_ST_PEND] = s_q.pend;
        state_word[`ITMR_ST_RUN] = cd.running;
    end

    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        evt_set = '0;

        // Serial writes
        if (io_wr) begin
            if (sel_is_mode) begin
                if (io_wdata) begin
                    s_d.mode = interval_timer_pkg::MODE_CLOCK;
                end else begin
                    s_d.mode = interval_timer_pkg::MODE_INTR;
                end
            end else if (s_q.mode == interval_timer_pkg::MODE_CLOCK) begin
                if (sel_in_interval) begin
                    s_d.interval[sel_idx - 4'h1] = io_wdata;
                    if (io_sel == `ITMR_SEL_INT_LAST) begin
                        s_d.start = 1'b1;
                    end
                end
            end else if (sel_in_mask) begin
                // Interrupt mode: selects 1..15 are the level masks
                s_d.level_mask[sel_idx] = io_wdata;
                if (io_sel == `ITMR_SEL_CLR && io_wdata) begin
                    s_d.pend = 1'b0;
                end
            end
        end

        // Expiry after the clear, so a coincident expiry is not lost
        if (cd.expired) begin
            s_d.pend = 1'b1;
        end
        s_d.int3 = s_d.pend && s_d.level_mask[3];

        // Snapshot runs while in interrupt mode and freezes on entry to clock mode
        if (s_q.mode == interval_timer_pkg::MODE_INTR) begin
            s_d.capture = cd.count;
        end

        // Serial read data, one cycle after the select
        if (sel_is_mode) begin
            s_d.io_rdata = s_q.mode;
        end else if (s_q.mode == interval_timer_pkg::MODE_CLOCK && sel_in_interval) begin
            s_d.io_rdata = s_q.capture[sel_idx - 4'h1];
        end else if (s_q.mode == interval_timer_pkg::MODE_CLOCK && io_sel == `ITMR_SEL_TOP) begin
            s_d.io_rdata = s_q.pend;
        end else if (sel_in_mask) begin
            s_d.io_rdata = s_q.level_mask[sel_idx];
        end else begin
            s_d.io_rdata = 1'b0;
        end

        // Avalon handshake: one wait cycle, then the accepting cycle
        s_d.waitreq = !av_first;
        if (av_first && read) begin
            unique case (address)
                `ITMR_OFF_STATUS: s_d.rdata = {{(32-`ITMR_EVT_W){1'b0}}, s_q.evt};
                `ITMR_OFF_MASK: s_d.rdata = {{(32-`ITMR_EVT_W){1'b0}}, s_q.evt_mask};
                `ITMR_OFF_STATE: s_d.rdata = state_word;
                default: s_d.rdata = '0;
            endcase
        end
        if (av_take && read && address == `ITMR_OFF_STATUS) begin
            // Clear only what the read returned; an event after the load survives
            s_d.evt = s_q.evt & ~s_q.rdata[`ITMR_EVT_W-1:0];
        end
        if (av_take && write && address == `ITMR_OFF_MASK) begin
            s_d.evt_mask = writedata[`ITMR_EVT_W-1:0];
        end

        // Sticky events; a set in the clearing cycle wins
        evt_set[`ITMR_EVT_EXPIRED] = cd.expired;
        evt_set[`ITMR_EVT_STARTED] = s_q.start;
        s_d.evt = s_d.evt | evt_set;
        s_d.irq = |(s_d.evt & s_d.evt_mask);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.mode <= interval_timer_pkg::MODE_INTR;
            s_q.interval <= `ITMR_RST_INTERVAL;
            s_q.level_mask <= `ITMR_RST_LEVEL_MASK;
            s_q.evt <= `ITMR_RST_EVT;
            s_q.evt_mask <= `ITMR_RST_EVT;
            s_q.rdata <= `ITMR_RST_RDATA;
            s_q.waitreq <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign io_rdata_q = s_q.io_rdata;
    assign int_level3_q = s_q.int3;
    assign readdata = s_q.rdata;
    assign waitrequest = s_q.waitreq;
    assign irq_q = s_q.irq;

endmodule : interval_timer
